// [src/cdu_pkg.sv]
`default_nettype none
package cdu_pkg;
  // ==========================================
  // Register addresses on the special register bus
  localparam logic [7:0] ADDR_DATA_LOW  = 8'h96;
  localparam logic [7:0] ADDR_DATA_HIGH = 8'h97;
  localparam logic [7:0] ADDR_CONTROL   = 8'hB9;

  // ==========================================
  // Control register layout
  localparam int CTL_EN_BIT  = 7;
  localparam int CTL_SRC_LSB = 4;
  localparam int CTL_RNG_LSB = 0;
  localparam logic [7:0] CTL_WRITE_MASK = 8'hF3;
  localparam logic [7:0] CTL_RESET      = 8'h72;
  localparam logic [7:0] LOW_WRITE_MASK = 8'hC0;
  localparam logic [7:0] DATA_RESET     = 8'h00;

  // ==========================================
  // Update source codes
  typedef enum logic [2:0] {
    SRC_TIMER0  = 3'h0,
    SRC_TIMER1  = 3'h1,
    SRC_TIMER2  = 3'h2,
    SRC_TIMER3  = 3'h3,
    SRC_RISE    = 3'h4,
    SRC_FALL    = 3'h5,
    SRC_ANY     = 3'h6,
    SRC_ONWRITE = 3'h7
  } cdu_src_t;

  // ==========================================
  // Full-scale range codes
  typedef enum logic [1:0] {
    RANGE_HALF_MA = 2'h0,
    RANGE_ONE_MA  = 2'h1,
    RANGE_TWO_MA  = 2'h2
  } cdu_range_t;
endpackage
`default_nettype wire

// [src/cdu_top.sv]
// Notes on behaviour
// - Control bit 7 enables the current converter; zero disables it.
// - Source codes 000..011 update on timer 0..3 overflow.
// - Source codes 100,101,110 update on rising, falling, any convert-start edge.
// - Source code 111 updates on high byte write; reset value of field.
// - Control bits 3:2 read zero, writes ignored.
// - Range 00 is 0.5 mA, 01 is 1.0 mA, 1x is 2.0 mA.
// - High data byte holds word bits 9:2, read/write, resets zero.
// - Low byte bits 7:6 hold word bits 1:0, left-justified.
// - Low byte bits 5:0 read zero, writes discarded.
// - Bias generator on when converter enabled or forced by software.
// - Timer modes hold both bytes until selected overflow, then copy word.
// - Edge modes hold both bytes until selected edge, then copy word.
// - Write mode holds low byte until high byte write; software writes low first.
`default_nettype none
module cdu_top
  import cdu_pkg::*;
#(
  parameter int DATA_W = 10
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // Special register bus
  input  wire logic [7:0]        reg_addr,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [7:0]        reg_wdata,
  output var  logic [7:0]        reg_rdata_q,
  // Update events and bias force input
  input  wire logic [3:0]        timer_overflow,
  input  wire logic              convert_start_input,
  input  wire logic              bias_generator_force_on,
  // Converter side
  output var  logic [DATA_W-1:0] dac_latch_q,
  output var  logic              converter_enable_q,
  output var  logic [1:0]        full_scale_range_q,
  output var  logic              bias_enable_q
);

  // ==========================================
  // Register file
  logic [7:0] control_q;
  logic [7:0] data_high_q;
  logic [7:0] data_low_q;
  cdu_src_t   src;
  logic       wr_ctl;
  logic       wr_high;
  logic       wr_low;

  assign src     = cdu_src_t'(control_q[CTL_SRC_LSB +: 3]);
  assign wr_ctl  = reg_wr && (reg_addr == ADDR_CONTROL);
  assign wr_high = reg_wr && (reg_addr == ADDR_DATA_HIGH);
  assign wr_low  = reg_wr && (reg_addr == ADDR_DATA_LOW);

  always_ff @(posedge clk) begin
    if (reset) begin
      control_q <= CTL_RESET;
    end else if (wr_ctl) begin
      control_q <= reg_wdata & CTL_WRITE_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      data_high_q <= DATA_RESET;
      data_low_q  <= DATA_RESET;
    end else begin
      if (wr_high) begin
        data_high_q <= reg_wdata;
      end
      if (wr_low) begin
        data_low_q <= reg_wdata & LOW_WRITE_MASK;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata_q <= DATA_RESET;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_CONTROL:   reg_rdata_q <= control_q;
        ADDR_DATA_HIGH: reg_rdata_q <= data_high_q;
        ADDR_DATA_LOW:  reg_rdata_q <= data_low_q;
        default:        reg_rdata_q <= DATA_RESET;
      endcase
    end
  end

  // ==========================================
  // Convert-start synchroniser and edge detect
  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  logic rise;
  logic fall;

  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
    end else begin
      sync1_q <= convert_start_input;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  assign rise = sync2_q && !prev_q;
  assign fall = !sync2_q && prev_q;

  // ==========================================
  // Update event selection
  logic update;

  always_comb begin
    unique case (src)
      SRC_TIMER0, SRC_TIMER1, SRC_TIMER2, SRC_TIMER3:
        update = timer_overflow[src[1:0]];
      SRC_RISE:    update = rise;
      SRC_FALL:    update = fall;
      SRC_ANY:     update = rise || fall;
      SRC_ONWRITE: update = wr_high;
    endcase
  end

  // In write mode the new high byte is taken from the bus so that it lands
  // in the same cycle; in other modes the held bytes are copied.
  always_ff @(posedge clk) begin
    if (reset) begin
      dac_latch_q <= '0;
    end else if (update) begin
      if (src == SRC_ONWRITE) begin
        dac_latch_q <= {reg_wdata, data_low_q[7:6]};
      end else begin
        dac_latch_q <= {data_high_q, data_low_q[7:6]};
      end
    end
  end

  // ==========================================
  // Converter controls
  always_ff @(posedge clk) begin
    if (reset) begin
      converter_enable_q <= 1'b0;
      full_scale_range_q <= RANGE_TWO_MA;
      bias_enable_q      <= 1'b0;
    end else begin
      converter_enable_q <= control_q[CTL_EN_BIT];
      // Upper bit set means 2 mA whatever the low bit holds
      if (control_q[CTL_RNG_LSB + 1]) begin
        full_scale_range_q <= RANGE_TWO_MA;
      end else begin
        full_scale_range_q <= control_q[CTL_RNG_LSB +: 2];
      end
      bias_enable_q <= control_q[CTL_EN_BIT] || bias_generator_force_on;
    end
  end

  // ==========================================
  // Checks
  a_reserved_ctl_zero: assert property (@(posedge clk) disable iff (reset)
    reg_rd && reg_addr == ADDR_CONTROL |=> reg_rdata_q[3:2] == 2'b00)
    else $error("control reserved bits not zero");

  a_low_unused_zero: assert property (@(posedge clk) disable iff (reset)
    reg_rd && reg_addr == ADDR_DATA_LOW |=> reg_rdata_q[5:0] == 6'h00)
    else $error("low byte unused bits not zero");

  a_enable_follows: assert property (@(posedge clk) disable iff (reset)
    wr_ctl |=> ##1 converter_enable_q == $past(reg_wdata[7], 2))
    else $error("enable does not follow control bit");

  a_range_decode: assert property (@(posedge clk) disable iff (reset)
    control_q[1] |=> full_scale_range_q == RANGE_TWO_MA)
    else $error("range 1x not decoded as 2 mA");

  a_bias_on: assert property (@(posedge clk) disable iff (reset)
    (control_q[7] || bias_generator_force_on) |=> bias_enable_q)
    else $error("bias not enabled");

  a_write_update: assert property (@(posedge clk) disable iff (reset)
    wr_high && src == SRC_ONWRITE
      |=> dac_latch_q[9:2] == $past(reg_wdata))
    else $error("high write did not update output");

  a_hold_timer: assert property (@(posedge clk) disable iff (reset)
    src == SRC_TIMER0 && !timer_overflow[0] |=> $stable(dac_latch_q))
    else $error("latch changed without timer overflow");

  a_low_held: assert property (@(posedge clk) disable iff (reset)
    wr_low && !update |=> $stable(dac_latch_q))
    else $error("low write reached output");

  a_rise_pulse: assert property (@(posedge clk) disable iff (reset)
    rise |=> !rise)
    else $error("edge pulse longer than one cycle");

  a_rise_update: assert property (@(posedge clk) disable iff (reset)
    src == SRC_RISE && rise && !wr_ctl
      |=> dac_latch_q == {$past(data_high_q), $past(data_low_q[7:6])})
    else $error("rising edge did not copy word");

  a_high_reset_zero: assert property (@(posedge clk)
    $past(reset) |-> data_high_q == DATA_RESET)
    else $error("high byte not zero after reset");

  a_timer_update: assert property (@(posedge clk) disable iff (reset)
    src == SRC_TIMER2 && timer_overflow[2]
      |=> dac_latch_q[9:2] == $past(data_high_q))
    else $error("timer 2 overflow did not update");

  // ==========================================
  // Further checks on the update paths
  // All three edge modes copy the held word as a whole, never one byte alone
  a_fall_update: assert property (@(posedge clk) disable iff (reset)
    src == SRC_FALL && fall
      |=> dac_latch_q == {$past(data_high_q), $past(data_low_q[7:6])})
    else $error("falling edge did not copy word");

  a_any_update: assert property (@(posedge clk) disable iff (reset)
    src == SRC_ANY && (rise || fall)
      |=> dac_latch_q == {$past(data_high_q), $past(data_low_q[7:6])})
    else $error("any edge did not copy word");

  a_rise_hold: assert property (@(posedge clk) disable iff (reset)
    src == SRC_RISE && !rise |=> $stable(dac_latch_q))
    else $error("latch changed without rising edge");

  a_fall_hold: assert property (@(posedge clk) disable iff (reset)
    src == SRC_FALL && !fall |=> $stable(dac_latch_q))
    else $error("latch changed without falling edge");

  a_any_hold: assert property (@(posedge clk) disable iff (reset)
    src == SRC_ANY && !rise && !fall |=> $stable(dac_latch_q))
    else $error("latch changed without any edge");

  a_fall_pulse: assert property (@(posedge clk) disable iff (reset)
    fall |=> !fall)
    else $error("falling pulse longer than one cycle");

  a_overflow_copy: assert property (@(posedge clk) disable iff (reset)
    !src[2] && timer_overflow[src[1:0]]
      |=> dac_latch_q == {$past(data_high_q), $past(data_low_q[7:6])})
    else $error("timer overflow did not copy word");

  // One hold check per timer, so a wrong index in the select shows up
  for (genvar t = 0; t < 4; t++) begin : g_timer_hold
    a_hold_each: assert property (@(posedge clk) disable iff (reset)
      !src[2] && src[1:0] == 2'(t) && !timer_overflow[t] |=> $stable(dac_latch_q))
      else $error("latch changed without its own timer overflow");
  end

  a_no_write_update: assert property (@(posedge clk) disable iff (reset)
    wr_high && src != SRC_ONWRITE && !update |=> $stable(dac_latch_q))
    else $error("high write reached output outside write mode");

  a_write_low_bits: assert property (@(posedge clk) disable iff (reset)
    wr_high && src == SRC_ONWRITE |=> dac_latch_q[1:0] == $past(data_low_q[7:6]))
    else $error("held low bits not used on high write");

  // ==========================================
  // Further checks on the register file
  a_high_written: assert property (@(posedge clk) disable iff (reset)
    wr_high |=> data_high_q == $past(reg_wdata))
    else $error("high byte not stored");

  a_low_stored: assert property (@(posedge clk) disable iff (reset)
    wr_low |=> data_low_q[7:6] == $past(reg_wdata[7:6]) && data_low_q[5:0] == 6'h00)
    else $error("low byte not stored left-justified");

  a_ctl_reserved_store: assert property (@(posedge clk) disable iff (reset)
    control_q[3:2] == 2'b00)
    else $error("control reserved bits hold ones");

  a_ctl_reset: assert property (@(posedge clk)
    $past(reset) |-> control_q[6:4] == 3'h7)
    else $error("update source not write mode after reset");

  // Unmapped addresses must not leak a stale register onto the bus
  a_unmapped_zero: assert property (@(posedge clk) disable iff (reset)
    reg_rd && reg_addr != ADDR_CONTROL && reg_addr != ADDR_DATA_HIGH
      && reg_addr != ADDR_DATA_LOW |=> reg_rdata_q == 8'h00)
    else $error("unmapped read not zero");

  // ==========================================
  // Further checks on the converter controls
  a_enable_low: assert property (@(posedge clk) disable iff (reset)
    !control_q[7] |=> !converter_enable_q)
    else $error("converter enabled with control bit clear");

  a_bias_off: assert property (@(posedge clk) disable iff (reset)
    !control_q[7] && !bias_generator_force_on |=> !bias_enable_q)
    else $error("bias on with no requester");

  a_range_low: assert property (@(posedge clk) disable iff (reset)
    !control_q[1] |=> full_scale_range_q == $past(control_q[1:0]))
    else $error("range 0x not passed through");

endmodule
`default_nettype wire

// [tb/tb_top.sv]
`default_nettype none
module tb_top
  import cdu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ====
  // Bench signals
  logic       clk, reset, reg_wr, reg_rd, convert_start_input, bias_generator_force_on;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_q, d;
  logic [3:0] timer_overflow;
  logic [9:0] dac_latch_q, cur;
  logic       converter_enable_q, bias_enable_q;
  logic [1:0] full_scale_range_q;
  int         mismatches, n_compared, cycles;

  cdu_top i_cdu_top (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .timer_overflow(timer_overflow), .convert_start_input(convert_start_input),
    .bias_generator_force_on(bias_generator_force_on), .dac_latch_q(dac_latch_q),
    .converter_enable_q(converter_enable_q), .full_scale_range_q(full_scale_range_q),
    .bias_enable_q(bias_enable_q));

  // ====
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("mismatches %0d n_compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ====
  // Bus helpers; inputs move 1 ns after the edge
  task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    cyc(1);
    reg_rd = 1'b0;
    d = reg_rdata_q;
  endtask

  // ====
  // Scenarios
  task automatic t_reset();
    rd(ADDR_CONTROL);
    chk(d, 10'h072, "ctl reset");
    rd(ADDR_DATA_HIGH);
    chk(d, 10'h000, "high reset");
    rd(ADDR_DATA_LOW);
    chk(d, 10'h000, "low reset");
    chk(full_scale_range_q, 10'h002, "range reset");
    chk({bias_enable_q, converter_enable_q}, 10'h000, "off after reset");
  endtask
  task automatic t_control();
    for (int r = 0; r < 4; r++) begin
      wr(ADDR_CONTROL, 8'hFC | 8'(r));
      rd(ADDR_CONTROL);
      chk(d, 10'h0F0 | 10'(r), "ctl readback");
      chk(full_scale_range_q, (r == 3) ? 10'h2 : 10'(r), "range");
      chk({bias_enable_q, converter_enable_q}, 10'h003, "enabled");
    end
    wr(ADDR_CONTROL, 8'h70);
    cyc(2);
    chk({bias_enable_q, converter_enable_q}, 10'h000, "disabled");
    bias_generator_force_on = 1'b1;
    cyc(2);
    chk(bias_enable_q, 10'h001, "forced bias");
    bias_generator_force_on = 1'b0;
  endtask
  task automatic t_write();
    wr(ADDR_CONTROL, 8'hF1);
    wr(ADDR_DATA_LOW, 8'hFF);
    rd(ADDR_DATA_LOW);
    chk(d, 10'h0C0, "low readback");
    chk(dac_latch_q, cur, "low held");
    wr(ADDR_DATA_HIGH, 8'hA5);
    cyc(2);
    cur = 10'h297;
    chk(dac_latch_q, cur, "high write update");
    rd(ADDR_DATA_HIGH);
    chk(d, 10'h0A5, "high readback");
    rd(8'h00);
    chk(d, 10'h000, "unmapped read");
  endtask
  task automatic t_rereset();
    reset = 1'b1;
    cyc(2);
    reset = 1'b0;
    cur = '0;
    chk(dac_latch_q, cur, "latch after reset");
    rd(ADDR_CONTROL);
    chk(d, 10'h072, "ctl after reset");
    wr(ADDR_DATA_HIGH, 8'h3C);
    cyc(1);
    cur = 10'h0F0;
    chk(dac_latch_q, cur, "write mode after reset");
  endtask
  task automatic pulse(input int k);
    timer_overflow = 4'h1 << k;
    cyc(1);
    timer_overflow = 4'h0;
    cyc(2);
  endtask
  task automatic t_timer();
    for (int n = 0; n < 4; n++) begin
      wr(ADDR_CONTROL, 8'h81 | 8'(n << 4));
      wr(ADDR_DATA_LOW, 8'h40);
      wr(ADDR_DATA_HIGH, 8'h10 + 8'(n));
      cyc(2);
      chk(dac_latch_q, cur, "held for timer");
      pulse((n + 1) % 4);
      chk(dac_latch_q, cur, "other timer ignored");
      pulse(n);
      cur = {8'h10 + 8'(n), 2'b01};
      chk(dac_latch_q, cur, "timer update");
    end
  endtask
  task automatic t_edge(input logic [7:0] ctl, input logic [1:0] hit);
    wr(ADDR_CONTROL, ctl);
    for (int e = 1; e >= 0; e--) begin
      wr(ADDR_DATA_HIGH, ctl + 8'(e));
      cyc(2);
      chk(dac_latch_q, cur, "held for edge");
      convert_start_input = e[0];
      cyc(5);
      if (hit[e]) cur = {ctl + 8'(e), 2'b01};
      chk(dac_latch_q, cur, "edge update");
    end
  endtask

  initial begin
    {reg_wr, reg_rd, convert_start_input, bias_generator_force_on} = 4'h0;
    {reg_addr, reg_wdata, timer_overflow, cur} = '0;
    reset = 1'b1;
    cyc(10);
    reset = 1'b0;
    t_reset();
    t_control();
    t_write();
    t_timer();
    t_edge(8'hC1, 2'b10);
    t_edge(8'hD1, 2'b01);
    t_edge(8'hE1, 2'b11);
    t_rereset();
    finish_test();
  end
endmodule
`default_nettype wire
